// [shared/usart_core_map.svh]
// Timing constants and reset values for the serial clock and receive buffer core.
`ifndef USART_CORE_MAP_SVH
`define USART_CORE_MAP_SVH
`define DIVISOR_W 12
`define DIVISOR_RESET 12'h000
`define OVS_NORMAL 5'h10
`define OVS_DOUBLE 5'h08
`define OVS_SYNC 5'h02
`define RX_FIFO_DEPTH 2
`define FILTER_TAPS 3
`define MCLK_PERIOD_NS 8
`endif

// [shared/usart_core_pkg.sv]
// Types shared by the serial clock and receive buffer core.
package usart_core_pkg;
    typedef enum logic [1:0] {
        CLK_ASYNC_NORMAL,
        CLK_ASYNC_DOUBLE,
        CLK_SYNC_MASTER,
        CLK_SYNC_SLAVE
    } clk_mode_e;
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_e;
    typedef struct packed {
        logic frame_err;
        logic overrun;
        logic ninth;
        logic parity_err;
        logic [7:0] data;
    } rx_entry_s;
endpackage

// [shared/rx_entry_if.sv]
// Handshake carrying completed characters from the receiver to the buffer.
`timescale 1ns/1ps
interface rx_entry_if;
    logic push;
    logic full;
    usart_core_pkg::rx_entry_s entry;
    modport src (output push, output entry, input full);
    modport dst (input push, input entry, output full);
endinterface

// [logic/baud_down_counter.sv]
// Down-counter baud generator with reload on zero or on a low-byte write.
`timescale 1ns/1ps
`include "usart_core_map.svh"
module baud_down_counter #(
    parameter int W = `DIVISOR_W
) (
    input wire logic mclk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [W-1:0] divisor, // Reload value.
    input wire logic reload, // Low-byte write strobe.
    output logic tick // One-cycle pulse at zero.
);
    logic [W-1:0] cnt_r;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (reload) begin
            cnt_r <= divisor; // [R4]
            tick <= 1'b0;
        end else if (cnt_r == '0) begin
            cnt_r <= divisor; // [R4]
            tick <= 1'b1; // [R5]
        end else begin
            cnt_r <= cnt_r - 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// [logic/rx_two_fifo.sv]
// Two-entry circular receive FIFO holding each character with its status.
`timescale 1ns/1ps
`include "usart_core_map.svh"
module rx_two_fifo (
    input wire logic mclk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    rx_entry_if.dst wr, // Push side.
    input wire logic pop, // Data read strobe.
    output usart_core_pkg::rx_entry_s head, // Entry at head.
    output logic not_empty // Unread data present.
);
    usart_core_pkg::rx_entry_s mem_r [`RX_FIFO_DEPTH];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic do_pop;
    logic do_push;
    assign do_pop = pop && cnt_r != 2'h0;
    assign do_push = wr.push && (cnt_r != 2'h2 || do_pop);
    assign wr.full = cnt_r == 2'h2;
    assign head = mem_r[rp_r]; // [R15]
    assign not_empty = cnt_r != 2'h0;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mem_r[0] <= '0; // [R23]
            mem_r[1] <= '0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (do_push) begin
                mem_r[wp_r] <= wr.entry; // [R15]
                wp_r <= ~wp_r; // [R14]
            end
            if (do_pop) begin
                rp_r <= ~rp_r; // [R14]
            end
            cnt_r <= cnt_r + {1'b0, do_push} - {1'b0, do_pop};
        end
    end
endmodule

// [logic/usart_clock_and_rx_buffer.sv]
// Clock generation, receiver recovery and buffering core of a serial port.
// How it works
// [R1] Four clock modes; sync_mode_select picks asynchronous or synchronous.
// [R2] In synchronous mode xck_direction output means master, input means slave.
// [R3] Transfer clock pin is driven or sampled only in synchronous mode.
// [R4] Baud down-counter reloads at zero and on a low-byte divisor write.
// [R5] One tick per zero, rate is clock over divisor plus one.
// [R6] Divisor is twelve bits, high and low parts, range 0 to 4095; with LEGACY set only the low byte is used, range 0 to 255.
// [R7] Transmit bit clock is tick over 16, 8 or 2 by mode.
// [R8] Receiver runs on the tick with 16, 8 or 2 states per bit.
// [R9] Software keeps double_speed clear in synchronous operation.
// [R10] Double speed makes the receiver use eight samples per bit.
// [R11] Slave clock is synchronised then edge detected, two cycles late.
// [R12] Remote master keeps transfer clock under a quarter of system clock.
// [R13] One transmit buffer ahead of the shift register for gapless frames.
// [R14] Receive data is a two-entry FIFO; each read pops one entry.
// [R15] Frame error, overrun and ninth bit stored with each entry.
// [R16] Software reads status before data because the read pops.
// [R17] With FIFO full, a new character waits in the shift register.
// [R18] Receiver reports frame, overrun and parity errors.
// [R19] Three events: transmit complete, data register empty, receive complete.
// [R20] Receiver filters noise and rejects false start bits.
// [R21] Legacy configuration allows asynchronous operation only.
// [R22] Polarity clear: change on rising, sample on falling; set swaps.
// [R23] Reset clears baud counter, FIFO contents and flags; FIFO empty.
`timescale 1ns/1ps
`include "usart_core_map.svh"
module usart_clock_and_rx_buffer #(
    parameter bit LEGACY = 1'b0
) (
    input wire logic mclk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic sync_mode_select, // 1 selects synchronous.
    input wire logic double_speed, // Asynchronous double speed.
    input wire logic xck_direction, // 1 means pin drives out (master).
    input wire logic clock_edge_polarity, // Synchronous edge swap.
    input wire logic [3:0] baud_divisor_high, // Divisor bits 11:8.
    input wire logic [7:0] baud_divisor_low, // Divisor bits 7:0.
    input wire logic baud_divisor_low_wr, // Low-byte write strobe.
    input wire logic parity_en, // Parity check enable.
    input wire logic parity_odd, // Odd parity.
    input wire logic nine_bits, // Nine-bit characters.
    input wire logic transfer_clock_pin_in, // Transfer clock pin level.
    output logic transfer_clock_pin_out, // Transfer clock drive.
    output logic transfer_clock_pin_oe_n, // Low while driving.
    input wire logic rxd, // Serial input.
    output logic txd_shift_en, // Transmit bit clock pulse.
    output logic tx_change_edge, // Synchronous data change pulse.
    input wire logic tx_data_wr, // Write to transmit buffer.
    input wire logic tx_shift_done, // Shift register finished a frame.
    output logic tx_load, // Move buffer to shift register.
    output logic data_register_empty, // Transmit buffer empty.
    output logic tx_complete, // Transmit complete pulse.
    input wire logic data_read, // Read of data buffer register.
    output logic [7:0] rx_data, // Head character.
    output logic frame_error_flag, // Head frame error.
    output logic overrun_flag, // Head overrun.
    output logic receive_ninth_bit, // Head ninth bit.
    output logic parity_error, // Head parity error.
    output logic receive_complete // Unread data present.
);
    logic sync_eff;
    logic slave;
    logic base_tick;
    logic [11:0] divisor;
    logic xck_s1_r;
    logic xck_s2_r;
    logic xck_d_r;
    logic xck_rise;
    logic xck_fall;
    logic [3:0] txdiv_r;
    logic [4:0] ovs;
    logic xcko_r;
    logic [2:0] filt_r;
    logic rx_bit;
    logic [4:0] phase_r;
    logic [3:0] bitcnt_r;
    logic [8:0] shift_r;
    logic par_r;
    logic held_r;
    logic ovr_pend_r;
    logic tx_buf_full_r;
    logic tx_busy_r;
    logic sample_now;
    logic in_sample_edge;
    usart_core_pkg::rx_state_e rx_st_r;
    usart_core_pkg::rx_entry_s head;
    logic not_empty;
    rx_entry_if rxq();

    assign sync_eff = sync_mode_select && !LEGACY; // [R1] [R21]
    assign slave = sync_eff && !xck_direction; // [R2]
    assign divisor = LEGACY ? {4'h0, baud_divisor_low} : {baud_divisor_high, baud_divisor_low}; // [R6]

    baud_down_counter #(.W(`DIVISOR_W)) u_baud (
        .mclk(mclk),
        .rst_n(rst_n),
        .divisor(divisor),
        .reload(baud_divisor_low_wr),
        .tick(base_tick)
    );

    // Samples per bit for the current mode.
    always_comb begin
        if (sync_eff) begin
            ovs = `OVS_SYNC; // [R8]
        end else if (double_speed) begin
            ovs = `OVS_DOUBLE; // [R10]
        end else begin
            ovs = `OVS_NORMAL; // [R8]
        end
    end

    // Slave clock synchroniser and edge detector.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            xck_s1_r <= 1'b0;
            xck_s2_r <= 1'b0;
            xck_d_r <= 1'b0;
        end else begin
            xck_s1_r <= slave ? transfer_clock_pin_in : 1'b0; // [R3] [R11]
            xck_s2_r <= xck_s1_r; // [R11]
            xck_d_r <= xck_s2_r;
        end
    end
    assign xck_rise = slave && xck_s2_r && !xck_d_r; // [R11]
    assign xck_fall = slave && !xck_s2_r && xck_d_r;

    // Transmit bit clock divider and master clock output.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            txdiv_r <= 4'h0;
            txd_shift_en <= 1'b0;
            tx_change_edge <= 1'b0;
            xcko_r <= 1'b0;
        end else if (slave) begin
            txdiv_r <= 4'h0;
            txd_shift_en <= clock_edge_polarity ? xck_fall : xck_rise; // [R22]
            tx_change_edge <= clock_edge_polarity ? xck_fall : xck_rise; // [R22]
            xcko_r <= 1'b0;
        end else begin
            txd_shift_en <= 1'b0;
            tx_change_edge <= 1'b0;
            if (base_tick) begin
                if ({1'b0, txdiv_r} >= ovs - 5'h01) begin
                    txdiv_r <= 4'h0;
                    txd_shift_en <= 1'b1; // [R7]
                end else begin
                    txdiv_r <= txdiv_r + 4'h1;
                end
                if (sync_eff) begin
                    xcko_r <= ~xcko_r; // [R7]
                    tx_change_edge <= !xcko_r; // [R22]
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            transfer_clock_pin_out <= 1'b0;
            transfer_clock_pin_oe_n <= 1'b1;
        end else begin
            transfer_clock_pin_out <= xcko_r ^ clock_edge_polarity;
            transfer_clock_pin_oe_n <= !(sync_eff && xck_direction); // [R3]
        end
    end

    // Majority filter on the input line.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            filt_r <= 3'h7;
        end else if (base_tick || slave) begin
            filt_r <= {filt_r[1:0], rxd}; // [R20]
        end
    end
    assign rx_bit = (filt_r[0] & filt_r[1]) | (filt_r[1] & filt_r[2]) | (filt_r[0] & filt_r[2]);

    // Sampling point: slave and master use the sample edge, async the bit centre.
    assign in_sample_edge = slave ? (clock_edge_polarity ? xck_rise : xck_fall)
                                  : (base_tick && sync_eff && xcko_r); // [R22]
    assign sample_now = sync_eff ? in_sample_edge
                                 : (base_tick && phase_r == (ovs >> 1)); // [R8]

    // Receiver state machine with third-level hold in the shift register.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_st_r <= usart_core_pkg::RX_IDLE;
            phase_r <= 5'h00;
            bitcnt_r <= 4'h0;
            shift_r <= 9'h000;
            par_r <= 1'b0;
            held_r <= 1'b0;
            ovr_pend_r <= 1'b0;
            rxq.push <= 1'b0;
            rxq.entry <= '0;
        end else begin
            rxq.push <= held_r && !rxq.full; // [R17]
            if (held_r && !rxq.full) begin
                held_r <= 1'b0;
            end
            if (base_tick && !sync_eff) begin
                phase_r <= (phase_r >= ovs - 5'h01) ? 5'h00 : phase_r + 5'h01; // [R8]
            end
            case (rx_st_r)
                usart_core_pkg::RX_IDLE: begin
                    if (!rx_bit && (sync_eff ? in_sample_edge : base_tick)) begin
                        if (held_r && rxq.full) begin
                            ovr_pend_r <= 1'b1; // [R17] [R18]
                            held_r <= 1'b0;
                        end
                        phase_r <= 5'h01;
                        rx_st_r <= sync_eff ? usart_core_pkg::RX_DATA
                                            : usart_core_pkg::RX_START;
                        bitcnt_r <= 4'h0;
                        par_r <= parity_odd;
                    end
                end
                usart_core_pkg::RX_START: begin
                    if (sample_now) begin
                        rx_st_r <= rx_bit ? usart_core_pkg::RX_IDLE // [R20]
                                          : usart_core_pkg::RX_DATA;
                    end
                end
                usart_core_pkg::RX_DATA: begin
                    if (sample_now) begin
                        shift_r <= {rx_bit, shift_r[8:1]};
                        par_r <= par_r ^ rx_bit;
                        bitcnt_r <= bitcnt_r + 4'h1;
                        if (bitcnt_r == (nine_bits ? 4'h8 : 4'h7) + {3'h0, parity_en}) begin
                            rx_st_r <= usart_core_pkg::RX_STOP;
                        end
                    end
                end
                usart_core_pkg::RX_STOP: begin
                    if (sample_now || sync_eff) begin
                        rx_st_r <= usart_core_pkg::RX_IDLE;
                        rxq.entry.frame_err <= !sync_eff && !rx_bit; // [R18]
                        rxq.entry.overrun <= ovr_pend_r; // [R15]
                        rxq.entry.parity_err <= parity_en && par_r; // [R18]
                        rxq.entry.ninth <= nine_bits ? shift_r[8 - {3'h0, parity_en}] : 1'b0;
                        rxq.entry.data <= (nine_bits || parity_en) ? shift_r[7:0] : shift_r[8:1];
                        ovr_pend_r <= 1'b0;
                        held_r <= 1'b1; // [R17]
                    end
                end
                default: rx_st_r <= usart_core_pkg::RX_IDLE;
            endcase
        end
    end

    rx_two_fifo u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr(rxq),
        .pop(data_read),
        .head(head),
        .not_empty(not_empty)
    );

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_data <= 8'h00;
            frame_error_flag <= 1'b0;
            overrun_flag <= 1'b0;
            receive_ninth_bit <= 1'b0;
            parity_error <= 1'b0;
            receive_complete <= 1'b0;
        end else begin
            rx_data <= head.data; // [R14]
            frame_error_flag <= head.frame_err; // [R15]
            overrun_flag <= head.overrun;
            receive_ninth_bit <= head.ninth;
            parity_error <= head.parity_err;
            receive_complete <= not_empty; // [R19]
        end
    end

    // Transmit buffer ahead of the shift register.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_buf_full_r <= 1'b0;
            tx_busy_r <= 1'b0;
            tx_load <= 1'b0;
            tx_complete <= 1'b0;
            data_register_empty <= 1'b1;
        end else begin
            tx_load <= 1'b0;
            tx_complete <= 1'b0;
            if (tx_buf_full_r && (!tx_busy_r || tx_shift_done)) begin
                tx_load <= 1'b1; // [R13]
                tx_buf_full_r <= tx_data_wr;
                tx_busy_r <= 1'b1;
            end else begin
                if (tx_data_wr) begin
                    tx_buf_full_r <= 1'b1;
                end
                if (tx_shift_done) begin
                    tx_busy_r <= 1'b0;
                    tx_complete <= 1'b1; // [R19]
                end
            end
            data_register_empty <= !(tx_buf_full_r || tx_data_wr); // [R19]
        end
    end
endmodule

// [test/usart_core_assertions.sv]
// Port-level checks for the serial clock and receive buffer core.
`timescale 1ns/1ps
`include "usart_core_map.svh"
module usart_core_assertions (
    input wire logic mclk, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic sync_mode_select, // Mode.
    input wire logic double_speed, // Speed.
    input wire logic xck_direction, // Pin way.
    input wire logic clock_edge_polarity, // Edge.
    input wire logic [3:0] baud_divisor_high, // Divisor.
    input wire logic [7:0] baud_divisor_low, // Divisor.
    input wire logic baud_divisor_low_wr, // Reload.
    input wire logic transfer_clock_pin_in, // Pin in.
    input wire logic transfer_clock_pin_oe_n, // Pin enable.
    input wire logic txd_shift_en, // Bit clock.
    input wire logic tx_change_edge, // Change.
    input wire logic tx_data_wr, // Write.
    input wire logic tx_shift_done, // Done.
    input wire logic tx_load, // Load.
    input wire logic data_register_empty, // Empty.
    input wire logic tx_complete, // Complete.
    input wire logic data_read, // Pop.
    input wire logic [7:0] rx_data, // Head.
    input wire logic frame_error_flag, // Head.
    input wire logic overrun_flag, // Head.
    input wire logic receive_complete // Unread.
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic master, slave, armed_r, busy_r;
    logic [4:0] ovs;
    logic [16:0] exp_gap, gap_r;
    logic [15:0] cfg, cfg_r;
    assign master = sync_mode_select && xck_direction;
    assign slave = sync_mode_select && !xck_direction;
    assign ovs = sync_mode_select ? `OVS_SYNC : (double_speed ? `OVS_DOUBLE : `OVS_NORMAL);
    assign exp_gap = 17'(ovs) * 17'({1'h0, baud_divisor_high, baud_divisor_low} + 13'h1);
    assign cfg = {sync_mode_select, double_speed, xck_direction, baud_divisor_low_wr,
        baud_divisor_high, baud_divisor_low};
    // A period counts only between two pulses with the setup left untouched.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gap_r <= 17'h00000;
            armed_r <= 1'h0;
            cfg_r <= 16'h0000;
        end else begin
            cfg_r <= cfg;
            gap_r <= txd_shift_en ? 17'h00001 : gap_r + 17'h00001;
            if (cfg != cfg_r) armed_r <= 1'h0;
            else if (txd_shift_en) armed_r <= 1'h1;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) busy_r <= 1'h0;
        else if (tx_load) busy_r <= 1'h1;
        else if (tx_shift_done) busy_r <= 1'h0;
    end
    chk_bit_period: assert property (txd_shift_en && armed_r && cfg == cfg_r && !slave
        |-> gap_r == exp_gap) else $error("bit clock period wrong");
    chk_master_drive: assert property (master[*2] |-> !transfer_clock_pin_oe_n)
        else $error("pin not driven in master mode");
    chk_pin_released: assert property ((!master)[*2] |-> transfer_clock_pin_oe_n)
        else $error("pin driven outside master mode");
    chk_slave_edge: assert property (slave && (clock_edge_polarity ?
        $fell(transfer_clock_pin_in) : $rose(transfer_clock_pin_in)) |-> ##[1:4] tx_change_edge)
        else $error("slave change edge missing");
    chk_load_idle: assert property (tx_data_wr && data_register_empty && !busy_r
        |-> ##2 tx_load ##1 data_register_empty) else $error("idle load missing");
    chk_load_refill: assert property (tx_shift_done && !data_register_empty |=> tx_load)
        else $error("buffered load missing");
    chk_tx_done: assert property (tx_shift_done && data_register_empty && !tx_data_wr
        |=> tx_complete) else $error("transmit complete missing");
    chk_rx_hold: assert property (receive_complete && !data_read && !$past(data_read)
        |=> receive_complete) else $error("unread data lost");
    chk_head_stable: assert property ((receive_complete && !data_read)[*3]
        |=> $stable(rx_data) && $stable(frame_error_flag) && $stable(overrun_flag))
        else $error("head changed without a read");
    cov_overrun: cover property (receive_complete && overrun_flag);
    cov_load: cover property (tx_load);
    cov_slave: cover property (slave && tx_change_edge);
endmodule
bind usart_clock_and_rx_buffer usart_core_assertions usart_core_assertions_i (.*);

// [test/remote_serial_node.sv]
// Behavioural remote node driving the receive line and the slave transfer clock.
`timescale 1ns/1ps
module remote_serial_node (
    input wire logic mclk, // System clock.
    output logic rxd, // Serial line.
    output logic transfer_clock_pin // Transfer clock.
);
    initial begin
        rxd = 1'h1;
        transfer_clock_pin = 1'h0;
    end
    task send_bit(input logic b, input int c);
        @(posedge mclk) rxd <= b;
        repeat (c - 1) @(posedge mclk);
    endtask
    // Start, data least significant first, optional parity, stop, then one idle bit.
    task send_frame(input logic [8:0] d, input int n, input logic par_en, input logic flip,
        input logic stop_bit, input int c);
        logic p;
        p = flip;
        send_bit(1'h0, c);
        for (int i = 0; i < n; i++) begin
            send_bit(d[i], c);
            p = p ^ d[i];
        end
        if (par_en) send_bit(p, c);
        send_bit(stop_bit, c);
        send_bit(1'h1, c);
    endtask
    // The clock rests at its idle level between bursts; half periods of four clocks.
    task clock_burst(input int n, input logic idle);
        @(posedge mclk) transfer_clock_pin <= idle;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge mclk) transfer_clock_pin <= (i % 2 == 0) ? !idle : idle;
            repeat (3) @(posedge mclk);
        end
    endtask
endmodule

// [test/usart_clock_and_rx_buffer_tb.sv]
// Self-checking bench for the serial clock and receive buffer core.
`timescale 1ns/1ps
module usart_clock_and_rx_buffer_tb;
    logic mclk, rst_n, sync_mode_select, double_speed, xck_direction, clock_edge_polarity;
    logic [3:0] baud_divisor_high;
    logic [7:0] baud_divisor_low, rx_data;
    logic baud_divisor_low_wr, parity_en, parity_odd, nine_bits, transfer_clock_pin, rxd, ov;
    logic transfer_clock_pin_out, transfer_clock_pin_oe_n, txd_shift_en, tx_change_edge;
    logic tx_data_wr, tx_shift_done, tx_load, data_register_empty, tx_complete, data_read;
    logic frame_error_flag, overrun_flag, receive_ninth_bit, parity_error, receive_complete;
    int errors, num_checks, edges, shifts, p;
    usart_core_pkg::rx_entry_s e;
    logic [15:0] exp_p [3] = '{16'h0060, 16'h0808, 16'h000C};
    logic [11:0] div_tab [3] = '{12'h005, 12'h100, 12'h005};
    usart_clock_and_rx_buffer usart_clock_and_rx_buffer_i (.*, .transfer_clock_pin_in(transfer_clock_pin));
    remote_serial_node remote_serial_node_i (.*);
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (tx_change_edge === 1'h1) edges++;
        if (txd_shift_en === 1'h1) shifts++;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task set_mode(input logic s, input logic d, input logic x, input logic [11:0] dv);
        @(posedge mclk);
        sync_mode_select <= s;
        double_speed <= d;
        xck_direction <= x;
        {baud_divisor_high, baud_divisor_low} <= dv;
        baud_divisor_low_wr <= 1'h1;
        @(posedge mclk) baud_divisor_low_wr <= 1'h0;
    endtask
    task measure(output int n);
        int k;
        k = 0;
        while (txd_shift_en !== 1'h1 && k < 9000) begin
            @(negedge mclk);
            k++;
        end
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (txd_shift_en !== 1'h1 && n < 9000);
    endtask
    task pop_rx(output usart_core_pkg::rx_entry_s r);
        int k;
        k = 0;
        while (receive_complete !== 1'h1 && k < 4000) begin
            @(negedge mclk);
            k++;
        end
        check(receive_complete, 1'h1);
        r = {frame_error_flag, overrun_flag, receive_ninth_bit, parity_error, rx_data};
        @(posedge mclk) data_read <= 1'h1;
        @(posedge mclk) data_read <= 1'h0;
        repeat (2) @(negedge mclk);
    endtask
    initial begin
        {sync_mode_select, double_speed, xck_direction, clock_edge_polarity} = 4'h0;
        {baud_divisor_high, baud_divisor_low, baud_divisor_low_wr} = 13'h0000;
        {parity_en, parity_odd, nine_bits, tx_data_wr, tx_shift_done, data_read} = 6'h00;
        rst_n = 1'h0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'h1;
        @(negedge mclk);
        check({receive_complete, data_register_empty, transfer_clock_pin_oe_n}, 16'h0003);
        check({rx_data, frame_error_flag, overrun_flag, parity_error, tx_load}, 16'h0000);
        for (int m = 0; m < 3; m++) begin
            set_mode(m == 2, m == 1, m == 2, div_tab[m]);
            measure(p);
            measure(p);
            check(16'(p), exp_p[m]);
            check(transfer_clock_pin_oe_n, m != 2);
            ov = transfer_clock_pin_out;
            repeat (6) @(negedge mclk);
            check(transfer_clock_pin_out ^ ov, m == 2);
        end
        @(posedge mclk) tx_data_wr <= 1'h1;
        @(posedge mclk) tx_data_wr <= 1'h0;
        @(negedge mclk);
        @(negedge mclk) check(tx_load, 1'h1);
        @(negedge mclk) check(data_register_empty, 1'h1);
        @(posedge mclk) tx_data_wr <= 1'h1;
        @(posedge mclk) tx_data_wr <= 1'h0;
        repeat (2) @(negedge mclk);
        check({tx_load, data_register_empty}, 16'h0000);
        @(posedge mclk) tx_shift_done <= 1'h1;
        @(posedge mclk) tx_shift_done <= 1'h0;
        @(negedge mclk) check(tx_load, 1'h1);
        @(posedge mclk) tx_shift_done <= 1'h1;
        @(posedge mclk) tx_shift_done <= 1'h0;
        @(negedge mclk) check(tx_complete, 1'h1);
        set_mode(1'h0, 1'h0, 1'h0, 12'h000);
        remote_serial_node_i.send_bit(1'h0, 1);
        remote_serial_node_i.send_bit(1'h1, 300);
        check(receive_complete, 1'h0);
        for (int i = 0; i < 3; i++) remote_serial_node_i.send_frame(9'h0A1 + 9'(i), 8, 0, 0, 1, 16);
        for (int i = 0; i < 3; i++) begin
            pop_rx(e);
            check(e, {4'h0, 8'hA1 + 8'(i)});
        end
        check(receive_complete, 1'h0);
        remote_serial_node_i.send_frame(9'h05A, 8, 0, 0, 0, 16);
        pop_rx(e);
        check(e, 12'h85A);
        @(posedge mclk) parity_en <= 1'h1;
        remote_serial_node_i.send_frame(9'h03C, 8, 1, 1, 1, 16);
        pop_rx(e);
        check(e, 12'h13C);
        @(posedge mclk) parity_odd <= 1'h1;
        remote_serial_node_i.send_frame(9'h03C, 8, 1, 1, 1, 16);
        pop_rx(e);
        check(e, 12'h03C);
        @(posedge mclk) {parity_en, parity_odd, nine_bits} <= 3'h1;
        remote_serial_node_i.send_frame(9'h1A5, 9, 0, 0, 1, 16);
        pop_rx(e);
        check(e, 12'h2A5);
        @(posedge mclk) nine_bits <= 1'h0;
        set_mode(1'h0, 1'h1, 1'h0, 12'h000);
        remote_serial_node_i.send_frame(9'h0C7, 8, 0, 0, 1, 8);
        pop_rx(e);
        check(e, 12'h0C7);
        set_mode(1'h0, 1'h0, 1'h0, 12'h000);
        for (int i = 0; i < 4; i++) remote_serial_node_i.send_frame(9'h010 + 9'(i), 8, 0, 0, 1, 16);
        ov = 1'h0;
        for (int i = 0; i < 3; i++) begin
            pop_rx(e);
            ov = ov | e.overrun;
            if (i < 2) check(e.data, 8'h10 + 8'(i));
        end
        check(ov, 1'h1);
        for (int pol = 0; pol < 2; pol++) begin
            @(posedge mclk) clock_edge_polarity <= pol[0];
            set_mode(1'h1, 1'h0, 1'h0, 12'h000);
            remote_serial_node_i.clock_burst(0, pol[0]);
            @(negedge mclk);
            edges = 0;
            shifts = 0;
            remote_serial_node_i.clock_burst(5, pol[0]);
            repeat (8) @(negedge mclk);
            check(16'(edges), 16'h0005);
            check(16'(shifts), 16'h0005);
        end
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
endmodule
